// ==== inc/rspf_cfg.svh ====
// Purpose: register map, field positions and reset values of the return stack pointer block
// Assumes: 32-bit classic wishbone slave, byte offsets, data in the low byte except the 21-bit top entry at 0x0c
// Notes: the package holds the types; this header holds every number
`ifndef RSPF_CFG_SVH
`define RSPF_CFG_SVH

`define RSPF_ADR_W 8
`define RSPF_OFS_SPSTAT 8'h00
`define RSPF_OFS_IRQ_STAT 8'h04
`define RSPF_OFS_IRQ_MASK 8'h08
`define RSPF_OFS_TOS 8'h0c

`define RSPF_BIT_FULL 7
`define RSPF_BIT_UNF 6
`define RSPF_BIT_RSVD 5
`define RSPF_SP_HI 4
`define RSPF_SP_W 5
`define RSPF_SP_EMPTY 5'h00
`define RSPF_SPSTAT_RST 8'h00

`define RSPF_IRQ_W 3
`define RSPF_IRQ_FULL 0
`define RSPF_IRQ_UNF 1
`define RSPF_IRQ_OVF 2
`define RSPF_IRQ_RST 3'h0

`define RSPF_RA_W 21
`define RSPF_DEPTH 31

`endif

// ==== inc/rspf_pkg.sv ====
// Purpose: types shared by the return stack pointer block
// Assumes: rspf_cfg.svh provides the widths
// Notes: structs carry the core request, the core answer and the pointer view
`include "rspf_cfg.svh"

package rspf_pkg;

  typedef enum logic [1:0] {
    RSPF_OP_IDLE,
    RSPF_OP_PUSH,
    RSPF_OP_POP
  } rspf_op_e;

  typedef struct packed {
    logic push;
    logic pop;
    logic [`RSPF_RA_W-1:0] push_addr;
  } rspf_req_s;

  typedef struct packed {
    logic valid;
    logic underflow;
    logic [`RSPF_RA_W-1:0] pc;
  } rspf_ans_s;

  typedef struct packed {
    logic full;
    logic unf;
    logic rsvd;
    logic [`RSPF_SP_W-1:0] loc;
  } rspf_spstat_s;

endpackage

// ==== rtl/rspf_stack_mem.sv ====
// Purpose: return address storage, one flop word per stack level
// Assumes: entry 0 is the empty level and always reads zero
// Notes: one write port, one combinational read port
`timescale 1ns/1ps
`include "rspf_cfg.svh"

module rspf_stack_mem #(
  parameter int RA_W = `RSPF_RA_W,
  parameter int DEPTH = `RSPF_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // write port
  input wire logic wr_en,
  input wire logic [`RSPF_SP_W-1:0] wr_idx,
  input wire logic [RA_W-1:0] wr_data,
  // read port
  input wire logic [`RSPF_SP_W-1:0] rd_idx,
  output logic [RA_W-1:0] rd_data
);

  generate
    if (DEPTH < 1 || DEPTH > (1 << `RSPF_SP_W) - 1) begin : g_bad_cfg
      $error("rspf_stack_mem: DEPTH must fit the pointer width");
    end
  endgenerate

  logic [RA_W-1:0] entry [1:DEPTH];

  genvar i;
  generate
    for (i = 1; i <= DEPTH; i++) begin : g_entry
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          entry[i] <= '0;
        end else if (wr_en && wr_idx == `RSPF_SP_W'(i)) begin
          entry[i] <= wr_data;
        end
      end
    end
  endgenerate

  // level 0 is the empty stack and doubles as the zero vector on an underflow pop;
  // indices above the depth read as zero instead of running off the array
  always_comb begin
    rd_data = '0;
    if (rd_idx != '0 && int'(rd_idx) <= DEPTH) begin
      rd_data = entry[rd_idx];
    end
  end

endmodule

// ==== rtl/rspf_top.sv ====
// Purpose: return address stack pointer with full and underflow flags
// Assumes: core push/pop requests come from logic on clk
// Notes: registers reached over classic wishbone, one level interrupt
`timescale 1ns/1ps
`include "rspf_cfg.svh"

module rspf_top #(
  parameter int RA_W = `RSPF_RA_W,
  parameter int DEPTH = `RSPF_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`RSPF_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core side
  input wire rspf_pkg::rspf_req_s core_req,
  output rspf_pkg::rspf_ans_s core_ans,
  // status
  output logic stack_full_flag,
  output logic stack_underflow_flag,
  output logic irq
);
  import rspf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // parameter checks

  generate
    if (RA_W != `RSPF_RA_W || DEPTH < 2 || DEPTH > (1 << `RSPF_SP_W) - 1) begin : g_bad_cfg
      $error("rspf_top: RA_W must match the package and DEPTH lie in 2..31");
    end
  endgenerate

  localparam logic [`RSPF_SP_W-1:0] TOP_SP = `RSPF_SP_W'(DEPTH);
  localparam logic [`RSPF_SP_W-1:0] SP_ONE = `RSPF_SP_W'(1);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [`RSPF_SP_W-1:0] sp;
  logic [`RSPF_SP_W-1:0] next_sp_up;
  logic [`RSPF_SP_W-1:0] wdat_sp;
  logic [RA_W-1:0] top_entry;
  rspf_op_e op;
  rspf_spstat_s spstat_view;
  logic [`RSPF_IRQ_W-1:0] irq_stat;
  logic [`RSPF_IRQ_W-1:0] irq_mask;
  logic [`RSPF_IRQ_W-1:0] irq_event;
  logic bus_req;
  logic wr_take;
  logic hit_sp;
  logic hit_stat;
  logic hit_mask;
  logic hit_tos;
  logic full_set;
  logic ovf_set;
  logic unf_set;
  logic full_clr;
  logic unf_clr;
  logic [31:0] rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // core request decode

  // a pop in the same cycle as a push wins; the push is dropped
  always_comb begin
    case ({core_req.pop, core_req.push})
      2'h2: op = RSPF_OP_POP;
      2'h3: op = RSPF_OP_POP;
      2'h1: op = RSPF_OP_PUSH;
      default: op = RSPF_OP_IDLE;
    endcase
  end

  assign next_sp_up = sp + SP_ONE;
  assign full_set = (op == RSPF_OP_PUSH) && (sp >= TOP_SP - SP_ONE);
  assign ovf_set = (op == RSPF_OP_PUSH) && (sp == TOP_SP);
  assign unf_set = (op == RSPF_OP_POP) && (sp == `RSPF_SP_EMPTY);

  ////////////////////////////////////////////////////////////////////////////
  // wishbone decode

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land on the edge where the master sees ack high
  assign wr_take = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign hit_sp = (wb_adr_i == `RSPF_OFS_SPSTAT);
  assign hit_stat = (wb_adr_i == `RSPF_OFS_IRQ_STAT);
  assign hit_mask = (wb_adr_i == `RSPF_OFS_IRQ_MASK);
  assign hit_tos = (wb_adr_i == `RSPF_OFS_TOS);
  assign wdat_sp = wb_dat_i[`RSPF_SP_HI:0];

  // flag bits clear on a written zero; a written one leaves them alone
  assign full_clr = wr_take && hit_sp && !wb_dat_i[`RSPF_BIT_FULL];
  assign unf_clr = wr_take && hit_sp && !wb_dat_i[`RSPF_BIT_UNF];

  ////////////////////////////////////////////////////////////////////////////
  // stack pointer

  // a core push or pop in the same cycle as a pointer write takes precedence
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sp <= `RSPF_SP_EMPTY;
    end else begin
      case (op)
        RSPF_OP_PUSH: begin
          if (sp != TOP_SP) begin
            sp <= next_sp_up;
          end
        end
        RSPF_OP_POP: begin
          if (sp != `RSPF_SP_EMPTY) begin
            sp <= sp - SP_ONE;
          end
        end
        default: begin
          if (wr_take && hit_sp) begin
            sp <= wdat_sp;
          end
        end
      endcase
    end
  end

  rspf_stack_mem #(
    .RA_W(RA_W),
    .DEPTH(DEPTH)
  ) rspf_stack_mem_inst (
    .clk(clk),
    .resetn(resetn),
    .wr_en((op == RSPF_OP_PUSH) && (sp != TOP_SP)),
    .wr_idx(next_sp_up),
    .wr_data(core_req.push_addr),
    .rd_idx(sp),
    .rd_data(top_entry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // flags

  // set wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stack_full_flag <= 1'b0;
    end else begin
      stack_full_flag <= full_set || (stack_full_flag && !full_clr);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stack_underflow_flag <= 1'b0;
    end else begin
      // only a software zero or reset drops the flag
      stack_underflow_flag <= unf_set || (stack_underflow_flag && !unf_clr);
    end
  end

  always_comb begin
    spstat_view.full = stack_full_flag;
    spstat_view.unf = stack_underflow_flag;
    spstat_view.rsvd = 1'b0;
    spstat_view.loc = sp;
  end

  ////////////////////////////////////////////////////////////////////////////
  // core answer

  // the underflow vector is only a zero pc: nothing else in the block is reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_ans <= '0;
    end else begin
      core_ans.valid <= (op == RSPF_OP_POP);
      core_ans.underflow <= unf_set;
      core_ans.pc <= unf_set ? '0 : top_entry;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  always_comb begin
    irq_event = '0;
    irq_event[`RSPF_IRQ_FULL] = full_set;
    irq_event[`RSPF_IRQ_UNF] = unf_set;
    irq_event[`RSPF_IRQ_OVF] = ovf_set;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat <= `RSPF_IRQ_RST;
    end else if (wr_take && hit_stat) begin
      irq_stat <= irq_event | (irq_stat & ~wb_dat_i[`RSPF_IRQ_W-1:0]);
    end else begin
      irq_stat <= irq_event | irq_stat;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask <= `RSPF_IRQ_RST;
    end else if (wr_take && hit_mask) begin
      irq_mask <= wb_dat_i[`RSPF_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone answer

  always_comb begin
    rd_word = '0;
    if (hit_sp) begin
      rd_word[`RSPF_BIT_FULL:0] = spstat_view;
    end else if (hit_stat) begin
      rd_word[`RSPF_IRQ_W-1:0] = irq_stat;
    end else if (hit_mask) begin
      rd_word[`RSPF_IRQ_W-1:0] = irq_mask;
    end else if (hit_tos) begin
      rd_word[RA_W-1:0] = top_entry;
    end
  end

  // one wait-free cycle: ack follows the request by one edge, drops the next
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // unmapped offsets still ack and read zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_dat_o <= '0;
    end else if (bus_req) begin
      wb_dat_o <= wb_we_i ? '0 : rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_unf_zero_pc: assert property (@(posedge clk) disable iff (!resetn)
    (op == RSPF_OP_POP && sp == `RSPF_SP_EMPTY) |=>
      (core_ans.valid && core_ans.underflow && core_ans.pc == '0))
    else $error("underflow pop did not return a zero pc");

  chk_unf_sp_hold: assert property (@(posedge clk) disable iff (!resetn)
    (op == RSPF_OP_POP && sp == `RSPF_SP_EMPTY) |=> (sp == `RSPF_SP_EMPTY))
    else $error("pointer moved on an underflow pop");

  chk_unf_sticky: assert property (@(posedge clk) disable iff (!resetn)
    (stack_underflow_flag && !unf_clr) |=> stack_underflow_flag)
    else $error("underflow flag dropped without a software clear");

  chk_unf_no_side: assert property (@(posedge clk) disable iff (!resetn)
    (unf_set && !wr_take) |=> ($stable(irq_mask) && $stable(stack_full_flag)))
    else $error("underflow vectoring disturbed other registers");

  chk_full_set: assert property (@(posedge clk) disable iff (!resetn)
    (op == RSPF_OP_PUSH && sp == TOP_SP - SP_ONE) |=>
      (stack_full_flag && sp == TOP_SP))
    else $error("full flag not set when the stack filled");

  chk_full_quiet: assert property (@(posedge clk) disable iff (!resetn)
    (!stack_full_flag && op != RSPF_OP_PUSH) |=> !stack_full_flag)
    else $error("full flag set without a push");

  chk_unf_bit: assert property (@(posedge clk) disable iff (!resetn)
    (bus_req && hit_sp && !wb_we_i) |=>
      (wb_dat_o[`RSPF_BIT_UNF] == $past(stack_underflow_flag)))
    else $error("underflow not visible below the full bit");

  chk_flag_clear: assert property (@(posedge clk) disable iff (!resetn)
    (full_clr && unf_clr && op == RSPF_OP_IDLE) |=>
      (!stack_full_flag && !stack_underflow_flag))
    else $error("software clear of the flags had no effect");

  chk_rsvd_zero: assert property (@(posedge clk) disable iff (!resetn)
    (bus_req && hit_sp && !wb_we_i) |=> (wb_ack_o && !wb_dat_o[`RSPF_BIT_RSVD]))
    else $error("unimplemented pointer bit read nonzero");

  chk_sp_write: assert property (@(posedge clk) disable iff (!resetn)
    (wr_take && hit_sp && op == RSPF_OP_IDLE) |=> (sp == $past(wdat_sp)))
    else $error("pointer write did not land");

  chk_push_inc: assert property (@(posedge clk) disable iff (!resetn)
    (op == RSPF_OP_PUSH && sp != TOP_SP) |=> (sp == $past(next_sp_up)))
    else $error("push did not advance the pointer");

  chk_pop_dec: assert property (@(posedge clk) disable iff (!resetn)
    (op == RSPF_OP_POP && sp != `RSPF_SP_EMPTY) ##1 1'b1 |->
      (sp == $past(sp) - SP_ONE))
    else $error("pop did not step the pointer back");

  chk_push_pop_pc: assert property (@(posedge clk) disable iff (!resetn)
    (op == RSPF_OP_PUSH && sp != TOP_SP) ##1 (op == RSPF_OP_POP) |=>
      (core_ans.pc == $past(core_req.push_addr, 2)))
    else $error("pop did not return the last pushed address");

  chk_ovf_keep: assert property (@(posedge clk) disable iff (!resetn)
    (op == RSPF_OP_PUSH && sp == TOP_SP) |=> (sp == TOP_SP && stack_full_flag))
    else $error("overflow push moved the pointer or missed the full flag");

  chk_full_sticky: assert property (@(posedge clk) disable iff (!resetn)
    (stack_full_flag && !full_clr) |=> stack_full_flag)
    else $error("full flag dropped without a software clear");

  chk_full_bit: assert property (@(posedge clk) disable iff (!resetn)
    (bus_req && hit_sp && !wb_we_i) |=>
      (wb_dat_o[`RSPF_BIT_FULL] == $past(stack_full_flag)))
    else $error("full flag not shown in the top pointer bit");

  chk_loc_read: assert property (@(posedge clk) disable iff (!resetn)
    (bus_req && hit_sp && !wb_we_i) |=> (wb_dat_o[`RSPF_SP_HI:0] == $past(sp)))
    else $error("pointer location read back wrong");

  // a push beside a pop is dropped, so an empty pop still leaves the pointer at zero
  chk_pop_wins: assert property (@(posedge clk) disable iff (!resetn)
    (core_req.pop && core_req.push && sp == `RSPF_SP_EMPTY) |=>
      (sp == `RSPF_SP_EMPTY && core_ans.underflow))
    else $error("push beside an empty pop moved the pointer");

  chk_ack_pulse: assert property (@(posedge clk) disable iff (!resetn)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held longer than one cycle");

  chk_irq_level: assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> (irq == $past(|(irq_stat & irq_mask))))
    else $error("interrupt does not follow unmasked status");

endmodule

// ==== verification/test_rspf_top.sv ====
// Purpose: self-checking bench for the return stack pointer block
// Assumes: classic wishbone, ack one cycle after a request, core ops one cycle pulses
// Notes: a small stack depth keeps the full and overflow cases short
`timescale 1ns/1ps
`include "rspf_cfg.svh"

module test_rspf_top;
  import rspf_pkg::*;

  localparam int DEPTH = 8;

  logic clk;
  logic resetn;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [`RSPF_ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  rspf_req_s core_req;
  rspf_ans_s core_ans;
  logic stack_full_flag;
  logic stack_underflow_flag;
  logic irq;
  int num_errors;
  int samples_checked;

  rspf_top #(.RA_W(`RSPF_RA_W), .DEPTH(DEPTH)) rspf_top_inst (
    .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_req(core_req), .core_ans(core_ans),
    .stack_full_flag(stack_full_flag), .stack_underflow_flag(stack_underflow_flag),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // request held until ack is sampled high, released right after that edge
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                         output logic [31:0] rd);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    // only the watchdog ends a wait for ack
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wb_xfer(1'b1, adr, dat, d);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string msg);
    logic [31:0] d;
    wb_xfer(1'b0, adr, 32'h0, d);
    chk_val(d, exp, msg);
  endtask

  task automatic core_op(input logic psh, input logic pp, input logic [20:0] a);
    @(posedge clk);
    core_req <= '{push: psh, pop: pp, push_addr: a};
    @(posedge clk);
    core_req <= '0;
    @(negedge clk);
  endtask

  task automatic pop_chk(input logic [20:0] exp_pc, input logic exp_unf);
    core_op(1'b0, 1'b1, 21'h0);
    chk_bit(core_ans.valid, 1'b1, "pop answer valid");
    chk_val(32'(core_ans.pc), 32'(exp_pc), "pop pc");
    chk_bit(core_ans.underflow, exp_unf, "pop underflow");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    rd_chk(`RSPF_OFS_SPSTAT, 32'h0, "pointer reset");
    rd_chk(`RSPF_OFS_IRQ_STAT, 32'h0, "status reset");
    rd_chk(`RSPF_OFS_IRQ_MASK, 32'h0, "mask reset");
    rd_chk(8'h10, 32'h0, "unmapped read");
  endtask

  task automatic t_push_pop();
    core_op(1'b1, 1'b0, 21'h1a5c3);
    core_op(1'b1, 1'b0, 21'h0f0f1);
    rd_chk(`RSPF_OFS_SPSTAT, 32'h02, "pointer after pushes");
    rd_chk(`RSPF_OFS_TOS, 32'h0f0f1, "top entry");
    pop_chk(21'h0f0f1, 1'b0);
    pop_chk(21'h1a5c3, 1'b0);
    rd_chk(`RSPF_OFS_SPSTAT, 32'h00, "pointer after pops");
  endtask

  // push then pop on consecutive edges, then a push beside an empty pop
  task automatic t_back_to_back();
    @(posedge clk);
    core_req <= '{push: 1'b1, pop: 1'b0, push_addr: 21'h15a5a};
    @(posedge clk);
    core_req <= '{push: 1'b0, pop: 1'b1, push_addr: 21'h0};
    @(posedge clk);
    core_req <= '0;
    @(negedge clk);
    chk_bit(core_ans.valid, 1'b1, "back to back valid");
    chk_val(32'(core_ans.pc), 32'h15a5a, "back to back pop pc");
    core_op(1'b1, 1'b1, 21'h00777);
    chk_bit(core_ans.underflow, 1'b1, "pop wins over push");
    rd_chk(`RSPF_OFS_SPSTAT, 32'h40, "push dropped, pointer zero");
    wr(`RSPF_OFS_SPSTAT, 32'h00);
    wr(`RSPF_OFS_IRQ_STAT, 32'h07);
  endtask

  task automatic t_underflow();
    wr(`RSPF_OFS_IRQ_MASK, 32'h05);
    pop_chk(21'h0, 1'b1);
    rd_chk(`RSPF_OFS_SPSTAT, 32'h40, "underflow flag, pointer zero");
    chk_bit(stack_underflow_flag, 1'b1, "underflow output");
    rd_chk(`RSPF_OFS_IRQ_STAT, 32'h02, "underflow event");
    rd_chk(`RSPF_OFS_IRQ_MASK, 32'h05, "mask kept");
    chk_bit(irq, 1'b0, "masked event no irq");
    core_op(1'b1, 1'b0, 21'h00123);
    rd_chk(`RSPF_OFS_SPSTAT, 32'h41, "flag survives push");
    wr(`RSPF_OFS_SPSTAT, 32'h7f);
    rd_chk(`RSPF_OFS_SPSTAT, 32'h5f, "write one keeps flag, bit5 zero");
    wr(`RSPF_OFS_SPSTAT, 32'h00);
    rd_chk(`RSPF_OFS_SPSTAT, 32'h00, "flag cleared by software");
    chk_bit(stack_underflow_flag, 1'b0, "underflow output cleared");
    wr(`RSPF_OFS_IRQ_STAT, 32'h07);
  endtask

  task automatic t_full();
    wr(`RSPF_OFS_SPSTAT, 32'(DEPTH - 1));
    rd_chk(`RSPF_OFS_SPSTAT, 32'(DEPTH - 1), "pointer below full");
    core_op(1'b1, 1'b0, 21'h00abc);
    rd_chk(`RSPF_OFS_SPSTAT, 32'h80 | 32'(DEPTH), "full flag");
    chk_bit(stack_full_flag, 1'b1, "full output");
    core_op(1'b1, 1'b0, 21'h00def);
    rd_chk(`RSPF_OFS_SPSTAT, 32'h80 | 32'(DEPTH), "overflow keeps pointer");
    rd_chk(`RSPF_OFS_TOS, 32'h00abc, "overflow no write");
    rd_chk(`RSPF_OFS_IRQ_STAT, 32'h05, "full and overflow events");
    wr(`RSPF_OFS_IRQ_MASK, 32'h01);
    rd_chk(`RSPF_OFS_IRQ_MASK, 32'h01, "mask write");
    chk_bit(irq, 1'b1, "unmasked irq");
    wr(`RSPF_OFS_IRQ_STAT, 32'h05);
    rd_chk(`RSPF_OFS_IRQ_STAT, 32'h00, "status cleared");
    chk_bit(irq, 1'b0, "irq cleared");
    pop_chk(21'h00abc, 1'b0);
    rd_chk(`RSPF_OFS_SPSTAT, 32'h80 | 32'(DEPTH - 1), "full flag sticky");
    wr(`RSPF_OFS_SPSTAT, 32'h00);
    rd_chk(`RSPF_OFS_SPSTAT, 32'h00, "full flag cleared");
    chk_bit(stack_full_flag, 1'b0, "full output cleared");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = '0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    core_req = '0;
    num_errors = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_reset_values();
    t_push_pop();
    t_back_to_back();
    t_underflow();
    t_full();
    give_verdict();
  end

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("ERROR %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
